// ===== bench/count_source_model.sv
// Far-side pin source: pulse bursts on the count input or the crystal input
`timescale 1ns/1ns
module count_source_model (
    input wire logic aclk,
    input wire logic start,
    input wire logic use_crystal,
    input wire logic [7:0] pulse_count,
    output logic count_pin,
    output logic crystal_pin,
    output logic done
);
    // A burst from idle low opens with a bare rising edge, which must not be counted
    initial begin
        count_pin = 1'b0;
        crystal_pin = 1'b0;
        done = 1'b1;
        forever begin
            @(posedge aclk);
            if (start) begin
                done <= 1'b0;
                repeat (pulse_count) begin
                    if (use_crystal) begin
                        crystal_pin <= 1'b1;
                    end else begin
                        count_pin <= 1'b1;
                    end
                    repeat (3) @(posedge aclk);
                    count_pin <= 1'b0;
                    crystal_pin <= 1'b0;
                    repeat (3) @(posedge aclk);
                end
                done <= 1'b1;
            end
        end
    end
endmodule

// ===== bench/tb_top.sv
// Self-checking testbench for the timer/counter core
`timescale 1ns/1ns
module tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, count_pin, crystal_pin, gate_level, sys_osc;
    logic crystal_driver_on, overflow_flag, unit1_high, unit2_high, start, use_crystal, done;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, port_c_dout, port_c_drive_req, pin_out, pin_oe, pin_read;
    logic [7:0] pulse_count;
    int fail_count = 0;
    int samples_checked = 0;
    int cycle = 0;
    int take_cycle, t0, e;
    typedef struct {logic [15:0] a; logic [7:0] d; logic [31:0] x; logic [1:0] r;} row_t;
    row_t rows [9] = '{'{16'h0000, 8'hfe, 32'hfe, 2'h0}, '{16'h0000, 8'h00, 32'h0, 2'h0},
        '{16'h0004, 8'hff, 32'h80, 2'h0}, '{16'h0004, 8'h00, 32'h0, 2'h0},
        '{16'h3d48, 8'hff, 32'h03, 2'h0}, '{16'h3d48, 8'h00, 32'h0, 2'h0},
        '{16'h0008, 8'h5a, 32'h5a, 2'h0}, '{16'h000c, 8'ha5, 32'ha5, 2'h0},
        '{16'h0020, 8'hff, 32'h0, 2'h2}};

    timer_counter_core #(.INSTR_DIV(2)) DUT (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .external_count_input(count_pin),
        .crystal_in_pin(crystal_pin), .gate_level(gate_level), .sys_clock_from_timer_osc(sys_osc),
        .port_c_dout(port_c_dout), .port_c_drive_req(port_c_drive_req), .port_c_pin_out(pin_out),
        .port_c_pin_oe(pin_oe), .port_c_read(pin_read), .crystal_driver_on(crystal_driver_on),
        .overflow_flag(overflow_flag), .capture_unit1_high_pair(unit1_high),
        .capture_unit2_high_pair(unit2_high));

    count_source_model PARTNER (.aclk(aclk), .start(start), .use_crystal(use_crystal),
        .pulse_count(pulse_count), .count_pin(count_pin), .crystal_pin(crystal_pin), .done(done));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) cycle <= cycle + 1;

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic aw_open, w_open;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_open = 1'b1;
        w_open = 1'b1;
        forever begin
            @(posedge aclk);
            if (aw_open && awready) begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
                take_cycle = cycle;
            end
            if (w_open && wready) begin
                wvalid <= 1'b0;
                w_open = 1'b0;
                take_cycle = cycle;
            end
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] x, input logic [31:0] got);
        samples_checked++;
        if (got !== x) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, x, got);
        end
    endtask

    task automatic chk_resp(input string name, input logic [1:0] x, input logic [1:0] got);
        samples_checked++;
        if (got !== x) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, x, got);
        end
    endtask

    // Bus latency puts the start and stop edges one cycle apart at worst, so allow one count
    task automatic chk_near(input string name, input int x, input logic [31:0] got);
        samples_checked++;
        if (^got === 1'bx || got > x + 1 || got + 1 < x) begin
            fail_count++;
            $display("unexpected %s: expected %0d, seen %h", name, x, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        fail_count++;
        $display("unexpected watchdog: expected end of run, seen timeout");
        stop_test;
    end

    initial begin
        {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        {gate_level, sys_osc, port_c_drive_req, start, use_crystal, pulse_count} = '0;
        wstrb = 4'h1;
        port_c_dout = 2'h1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk_resp("write response", rows[i].r, rs);
            rd_reg(rows[i].a);
            chk_resp("read response", rows[i].r, rs);
            chk("read data", rows[i].x, rd);
        end
        $display("register table done");
        for (int c = 0; c < 4; c++) begin
            wr(timer_counter_pkg::OFS_CLOCK_CONTROL, 8'(c));
            chk("pairs", 32'({c == 2, c == 1 || c == 2}), 32'({unit1_high, unit2_high}));
        end
        sys_osc <= 1'b1;
        rd_reg(timer_counter_pkg::OFS_CLOCK_CONTROL);
        chk("clock control", 32'h13, rd);
        sys_osc <= 1'b0;
        $display("clock control done");
        wr(timer_counter_pkg::OFS_GATE_CONTROL, 8'h80);
        for (int k = 0; k < 6; k++) begin
            gate_level <= (k != 5);
            wr(timer_counter_pkg::OFS_TIMER_CONTROL,
               8'((k == 4 ? 0 : 64) + (k < 4 ? k * 16 : 0) + 1));
            wr(timer_counter_pkg::OFS_COUNT_LOW, 8'h00);
            t0 = take_cycle;
            repeat (150) @(posedge aclk);
            wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'h00);
            e = (k == 5) ? 0 : (take_cycle - t0) / (k == 4 ? 2 : 1 << k);
            rd_reg(timer_counter_pkg::OFS_COUNT_LOW);
            chk_near("timed count", e, rd);
        end
        // The last timed case closed the gate; reopen it or nothing below can count
        gate_level <= 1'b1;
        $display("timed counting done");
        wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'h02);
        wr(timer_counter_pkg::OFS_COUNT_HIGH, 8'h12);
        wr(timer_counter_pkg::OFS_COUNT_LOW, 8'h34);
        wr(timer_counter_pkg::OFS_COUNT_HIGH, 8'h77);
        rd_reg(timer_counter_pkg::OFS_COUNT_HIGH);
        chk("high buffer", 32'h77, rd);
        rd_reg(timer_counter_pkg::OFS_COUNT_LOW);
        chk("low byte", 32'h34, rd);
        rd_reg(timer_counter_pkg::OFS_COUNT_HIGH);
        chk("captured high", 32'h12, rd);
        wr(timer_counter_pkg::OFS_COUNT_HIGH, 8'hff);
        wr(timer_counter_pkg::OFS_COUNT_LOW, 8'hfd);
        wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'h43);
        while (overflow_flag !== 1'b1) @(posedge aclk);
        wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'h02);
        rd_reg(timer_counter_pkg::OFS_COUNT_LOW);
        rd_reg(timer_counter_pkg::OFS_COUNT_HIGH);
        chk("high after wrap", 32'h0, rd);
        rd_reg(timer_counter_pkg::OFS_FLAGS);
        chk("flag set", 32'h1, rd);
        wr(timer_counter_pkg::OFS_FLAGS, 8'h01);
        rd_reg(timer_counter_pkg::OFS_FLAGS);
        chk("flag cleared", 32'h0, rd);
        chk("flag output", 32'h0, {31'h0, overflow_flag});
        $display("wide access and overflow done");
        port_c_drive_req <= 2'h3;
        for (int m = 0; m < 4; m++) begin
            wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'(128 + m * 4));
            wr(timer_counter_pkg::OFS_COUNT_LOW, 8'h00);
            repeat (20) @(posedge aclk);
            chk("crystal enable", 32'(m >> 1), {31'h0, crystal_driver_on});
            chk("pin enables off", 32'h3, {30'h0, pin_oe});
            chk("pin data", 32'h1, {30'h0, pin_out});
            wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'(129 + m * 4));
            // The enables are registered one edge after the control write lands
            @(negedge aclk);
            chk("pin enables on", 32'h0, {30'h0, pin_oe});
            @(posedge aclk);
            use_crystal <= (m >= 2);
            pulse_count <= 8'h05;
            start <= 1'b1;
            @(posedge aclk);
            start <= 1'b0;
            @(posedge aclk);
            while (done !== 1'b1) begin
                @(posedge aclk);
                chk("pin reads", 32'h0, {30'h0, pin_read});
            end
            repeat (6) @(posedge aclk);
            wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'(128 + m * 4));
            rd_reg(timer_counter_pkg::OFS_COUNT_LOW);
            chk("external count", 32'h4, rd);
        end
        $display("external counting done");
        wr(timer_counter_pkg::OFS_TIMER_CONTROL, 8'h0e);
        wr(timer_counter_pkg::OFS_CLOCK_CONTROL, 8'h03);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(timer_counter_pkg::OFS_TIMER_CONTROL);
        chk("control after reset", 32'h0, rd);
        chk("crystal after reset", 32'h0, {31'h0, crystal_driver_on});
        rd_reg(timer_counter_pkg::OFS_CLOCK_CONTROL);
        chk("clock control after reset", 32'h0, rd);
        $display("mid-run reset done");
        stop_test;
    end
endmodule

// ===== hw/timer_counter_core.sv
// 16-bit incrementing timer/counter with prescaler, wide access buffer and AXI4-Lite registers
// Functional notes
// - clock-control bit 4 reads 1 while system clock comes from timer oscillator.
// - two-bit field assigns timer pairs to the two capture units.
// - unused clock-control bits read zero and ignore writes.
// - incrementing 16-bit counter, reached as high and low byte.
// - clock select and crystal driver bit pick the count source.
// - internal source makes a timer advancing per instruction cycle via prescaler.
// - internal source advances on multiples of system clock per prescaler.
// - external source counts rising edges, synchronised or not.
// - counting enabled by counter-on, and gated by the gate pin when gate-enable is set.
// - while enabled, the two count pins are inputs and read as zero.
// - external mode needs a falling edge before the first counted rising edge.
// - wide mode: low byte read copies live high byte into buffer.
// - wide mode: high writes go to buffer; low write loads all 16 bits.
// - wide mode: live high byte never accessed directly.
// - low byte write clears prescaler; high byte write does not.
// - crystal driver enable starts the oscillator, which keeps running.
// - prescale codes 00..11 divide by 1, 2, 4, 8.
// - sync-disable bit chooses synchronised or raw external edges.
// - wide mode clear: bytes are two independent 8-bit registers.
// - counter rolls from all ones to zero and latches the overflow flag.
`timescale 1ns/1ns
module timer_counter_core #(
    parameter int INSTR_DIV = timer_counter_pkg::INSTR_CLOCK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [timer_counter_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [timer_counter_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [timer_counter_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [timer_counter_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic external_count_input,
    input wire logic crystal_in_pin,
    input wire logic gate_level,
    input wire logic sys_clock_from_timer_osc,
    input wire logic [1:0] port_c_dout,
    input wire logic [1:0] port_c_drive_req,
    output logic [1:0] port_c_pin_out,
    output logic [1:0] port_c_pin_oe,
    output logic [1:0] port_c_read,
    output logic crystal_driver_on,
    output logic overflow_flag,
    output logic capture_unit1_high_pair,
    output logic capture_unit2_high_pair
);
    generate
        if (INSTR_DIV < 2 || INSTR_DIV > 256) begin : g_bad_div
            $error("INSTR_DIV must lie between 2 and 256");
        end
    endgenerate

    timer_counter_pkg::timer_control_t tcon;
    logic gate_count_enable;
    logic [1:0] capture_timer_assign;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic [2:0] pre_cnt;
    logic [7:0] instr_cnt;
    logic armed;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic src_prev;
    logic rise_slow;

    logic aw_held;
    logic w_held;
    logic [15:0] aw_addr_q;
    logic [7:0] wd_q;
    logic ws_q;

    // Pin order: 0 count input / crystal out, 1 crystal in, 2 gate
    wire [2:0] pin_raw = {gate_level, crystal_in_pin, external_count_input};

    // Bus decode
    wire do_write = aw_held && w_held && !bvalid;
    wire wr_en = do_write && ws_q;
    wire wr_sel_tcon = aw_addr_q == timer_counter_pkg::OFS_TIMER_CONTROL;
    wire wr_sel_gate = aw_addr_q == timer_counter_pkg::OFS_GATE_CONTROL;
    wire wr_sel_low = aw_addr_q == timer_counter_pkg::OFS_COUNT_LOW;
    wire wr_sel_high = aw_addr_q == timer_counter_pkg::OFS_COUNT_HIGH;
    wire wr_sel_flags = aw_addr_q == timer_counter_pkg::OFS_FLAGS;
    wire wr_sel_clk = aw_addr_q == timer_counter_pkg::OFS_CLOCK_CONTROL;
    wire wr_mapped = wr_sel_tcon | wr_sel_gate | wr_sel_low | wr_sel_high | wr_sel_flags
                     | wr_sel_clk;

    wire ar_fire = arvalid && arready;
    wire rd_sel_tcon = araddr == timer_counter_pkg::OFS_TIMER_CONTROL;
    wire rd_sel_gate = araddr == timer_counter_pkg::OFS_GATE_CONTROL;
    wire rd_sel_low = araddr == timer_counter_pkg::OFS_COUNT_LOW;
    wire rd_sel_high = araddr == timer_counter_pkg::OFS_COUNT_HIGH;
    wire rd_sel_flags = araddr == timer_counter_pkg::OFS_FLAGS;
    wire rd_sel_clk = araddr == timer_counter_pkg::OFS_CLOCK_CONTROL;
    wire rd_mapped = rd_sel_tcon | rd_sel_gate | rd_sel_low | rd_sel_high | rd_sel_flags
                     | rd_sel_clk;

    wire low_wr = wr_en && wr_sel_low;
    wire high_wr = wr_en && wr_sel_high;
    wire wide = tcon.wide_access_mode;
    wire live_high_wr = high_wr && !wide;
    wire count_wr = low_wr || live_high_wr;
    wire flag_clear = wr_en && wr_sel_flags && wd_q[timer_counter_pkg::OVERFLOW_BIT];

    // Count source
    wire instr_tick = instr_cnt == 8'(INSTR_DIV - 1);
    wire ext_src = tcon.crystal_driver_enable ? pin_sync[1] : pin_sync[0];
    wire rise_fast = ext_src && !src_prev;
    wire fall_fast = !ext_src && src_prev;
    wire ext_rise = tcon.external_sync_disable ? rise_fast : rise_slow;
    wire ext_mode = tcon.count_clock_select == timer_counter_pkg::CLK_SEL_EXTERNAL;
    logic src_tick;
    always_comb begin
        case (tcon.count_clock_select)
            timer_counter_pkg::CLK_SEL_INSTRUCTION: src_tick = instr_tick;
            timer_counter_pkg::CLK_SEL_SYSTEM: src_tick = 1'b1;
            timer_counter_pkg::CLK_SEL_EXTERNAL: src_tick = armed && ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    wire running = tcon.counter_on && (!gate_count_enable || pin_sync[2]);
    wire [2:0] pre_limit = (3'h1 << tcon.input_prescale_select) - 3'h1;
    wire pre_step = src_tick && running;
    wire pre_done = pre_step && pre_cnt == pre_limit;
    wire overflow_set = pre_done && !count_wr && count == 16'hffff;

    // Read data
    wire [7:0] clk_read = {3'h0, sys_clock_from_timer_osc, 2'h0, capture_timer_assign};
    wire [7:0] high_read = wide ? high_buffer : count[15:8];
    wire [7:0] rd_byte = rd_sel_tcon ? tcon :
                         rd_sel_gate ? {gate_count_enable, 7'h00} :
                         rd_sel_low ? count[7:0] :
                         rd_sel_high ? high_read :
                         rd_sel_flags ? {7'h00, overflow_flag} :
                         rd_sel_clk ? clk_read : 8'h00;

    assign awready = !aw_held;
    assign wready = !w_held;
    assign arready = !rvalid;
    assign crystal_driver_on = tcon.crystal_driver_enable;
    assign capture_unit1_high_pair = capture_timer_assign
                                     == timer_counter_pkg::CAPTURE_BOTH_HIGH;
    assign capture_unit2_high_pair = capture_timer_assign == timer_counter_pkg::CAPTURE_SPLIT
                                     || capture_unit1_high_pair;

    // Pins pass two flops before any logic reads them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // The retimed edge costs one cycle; the raw path trades that for lower latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev <= 1'b0;
            rise_slow <= 1'b0;
        end else begin
            src_prev <= ext_src;
            rise_slow <= rise_fast;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_cnt <= 8'h00;
        end else if (instr_tick) begin
            instr_cnt <= 8'h00;
        end else begin
            instr_cnt <= instr_cnt + 8'h01;
        end
    end

    // Disarm on disable or count write so a high input is not mistaken for an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
        end else if (!tcon.counter_on || count_wr) begin
            armed <= 1'b0;
        end else if (fall_fast) begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt <= 3'h0;
        end else if (low_wr) begin
            pre_cnt <= 3'h0;
        end else if (pre_done) begin
            pre_cnt <= 3'h0;
        end else if (pre_step) begin
            pre_cnt <= pre_cnt + 3'h1;
        end
    end

    // Writes take precedence over an increment in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
        end else if (low_wr && wide) begin
            count <= {high_buffer, wd_q};
        end else if (low_wr) begin
            count <= {count[15:8], wd_q};
        end else if (live_high_wr) begin
            count <= {wd_q, count[7:0]};
        end else if (pre_done) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_buffer <= 8'h00;
        end else if (high_wr && wide) begin
            high_buffer <= wd_q;
        end else if (ar_fire && rd_sel_low && wide) begin
            high_buffer <= count[15:8];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
        end else if (overflow_set) begin
            overflow_flag <= 1'b1;
        end else if (flag_clear) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tcon <= timer_counter_pkg::TIMER_CONTROL_RESET;
            gate_count_enable <= 1'b0;
            capture_timer_assign <= timer_counter_pkg::CAPTURE_ASSIGN_RESET;
        end else if (wr_en) begin
            if (wr_sel_tcon) begin
                tcon <= wd_q;
            end
            if (wr_sel_gate) begin
                gate_count_enable <= wd_q[timer_counter_pkg::GATE_ENABLE_BIT];
            end
            if (wr_sel_clk) begin
                capture_timer_assign <= wd_q[1:0];
            end
        end
    end

    // Pin ownership: enabled counter forces inputs and masks the port read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_c_pin_oe <= 2'h0;
            port_c_read <= 2'h0;
            port_c_pin_out <= 2'h0;
        end else begin
            port_c_pin_oe <= tcon.counter_on ? 2'h0 : port_c_drive_req;
            port_c_read <= tcon.counter_on ? 2'h0 : pin_sync[1:0];
            port_c_pin_out <= port_c_dout;
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 16'h0000;
            wd_q <= 8'h00;
            ws_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= timer_counter_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wd_q <= wdata[7:0];
                ws_q <= wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_mapped ? timer_counter_pkg::RESP_OKAY : timer_counter_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= timer_counter_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_mapped ? timer_counter_pkg::RESP_OKAY : timer_counter_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    AST_OSC_ACTIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_sel_clk) |=> rdata[4] == $past(sys_clock_from_timer_osc))
        else $error("osc clock active bit misreported");
    AST_CLK_UNUSED: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_sel_clk) |=> rdata[7:5] == 3'h0 && rdata[3:2] == 2'h0)
        else $error("unused clock control bits not zero");
    AST_PRESCALE_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        (pre_step && !low_wr && pre_cnt != pre_limit)
        |=> pre_cnt == $past(pre_cnt) + 3'h1 && (count == $past(count) || $past(count_wr)))
        else $error("prescaler step wrong");
    AST_COUNT_INC: assert property (@(posedge aclk) disable iff (!aresetn)
        (pre_done && !count_wr) |=> count == $past(count) + 16'h0001)
        else $error("counter did not advance");
    AST_ROLLOVER: assert property (@(posedge aclk) disable iff (!aresetn)
        (pre_done && !count_wr && count == 16'hffff) |=> count == 16'h0000 && overflow_flag)
        else $error("rollover or overflow flag wrong");
    AST_PRESCALE_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        low_wr |=> pre_cnt == 3'h0)
        else $error("low byte write left prescaler");
    AST_WIDE_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        (low_wr && wide) |=> count == {$past(high_buffer), $past(wd_q)})
        else $error("wide write not atomic");
    AST_WIDE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_sel_high && wide) |=> rdata[7:0] == $past(high_buffer))
        else $error("wide high read bypassed buffer");
    AST_PINS_INPUT: assert property (@(posedge aclk) disable iff (!aresetn)
        tcon.counter_on ##1 tcon.counter_on |-> port_c_pin_oe == 2'h0 && port_c_read == 2'h0)
        else $error("count pins not forced to inputs");
    AST_ARMING: assert property (@(posedge aclk) disable iff (!aresetn)
        (ext_mode && !armed && !count_wr) |=> count == $past(count))
        else $error("counted before a falling edge");
    AST_DISABLED_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (!tcon.counter_on && !count_wr)[*2] |-> $stable(count))
        else $error("counter moved while disabled");
endmodule

// ===== hw/timer_counter_pkg.sv
// Register map, field layouts and encodings for the 16-bit timer/counter core
package timer_counter_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // The clock control register keeps its printed index; byte address is four times it
    localparam logic [11:0] CLOCK_CONTROL_INDEX = 12'hf52;
    localparam logic [15:0] OFS_CLOCK_CONTROL = {2'h0, CLOCK_CONTROL_INDEX, 2'h0};
    localparam logic [15:0] OFS_TIMER_CONTROL = 16'h0000;
    localparam logic [15:0] OFS_GATE_CONTROL = 16'h0004;
    localparam logic [15:0] OFS_COUNT_LOW = 16'h0008;
    localparam logic [15:0] OFS_COUNT_HIGH = 16'h000c;
    localparam logic [15:0] OFS_FLAGS = 16'h0010;

    typedef struct packed {
        logic [1:0] count_clock_select;
        logic [1:0] input_prescale_select;
        logic crystal_driver_enable;
        logic external_sync_disable;
        logic wide_access_mode;
        logic counter_on;
    } timer_control_t;

    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [1:0] CAPTURE_ASSIGN_RESET = 2'h0;

    localparam logic [1:0] CLK_SEL_INSTRUCTION = 2'h0;
    localparam logic [1:0] CLK_SEL_SYSTEM = 2'h1;
    localparam logic [1:0] CLK_SEL_EXTERNAL = 2'h2;

    localparam logic [1:0] CAPTURE_BOTH_LOW = 2'h0;
    localparam logic [1:0] CAPTURE_SPLIT = 2'h1;
    localparam logic [1:0] CAPTURE_BOTH_HIGH = 2'h2;

    localparam int OSC_ACTIVE_BIT = 4;
    localparam int GATE_ENABLE_BIT = 7;
    localparam int OVERFLOW_BIT = 0;

    localparam int INSTR_CLOCK_DIV = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
